//--- spcr_pkg.sv
// Package: offsets, field positions and reset values of the port id/command registers
package spcr_pkg;
    localparam logic [7:0]  OFF_IDENT     = 8'h00;
    localparam logic [7:0]  OFF_COMMAND   = 8'h04;
    localparam int          VEND_LSB      = 0;
    localparam int          PART_LSB      = 16;
    // Arbitrary neutral identity defaults, not any real maker or part
    localparam logic [15:0] MAKER_ID_RST  = 16'h0a5a;
    localparam logic [15:0] PART_ID_RST   = 16'h0c3c;
    localparam int          CMD_IO_EN     = 0;
    localparam int          CMD_MEM_EN    = 1;
    localparam int          CMD_BM_EN     = 2;
    localparam int          CMD_PERR_RESP = 6;
    localparam int          CMD_ERR_REP   = 8;
    localparam int          CMD_INT_DIS   = 10;
    // Only these bits hold state; all others read zero
    localparam logic [15:0] CMD_WR_MASK   = 16'h0547;
    localparam logic [15:0] CMD_RST       = 16'h0000;
    typedef enum logic [1:0] {
        SPCR_RSP_NONE = 2'b00,
        SPCR_RSP_OK   = 2'b01,
        SPCR_RSP_UR   = 2'b10
    } spcr_rsp_t;
endpackage

//--- spcr_gate.sv
// Transaction gating decisions driven by the command bits
`timescale 1ns/100ps
module spcr_gate (
    input  wire logic       io_en,
    input  wire logic       mem_en,
    input  wire logic       bm_en,
    input  wire logic       perr_resp,
    input  wire logic       err_rep,
    input  wire logic       int_dis,
    input  wire logic       pri_req,
    input  wire logic       pri_is_io,
    input  wire logic       dn_req,
    input  wire logic       dn_nonposted,
    input  wire logic       parity_err,
    input  wire logic       err_event,
    input  wire logic       own_intx,
    input  wire logic       fwd_intx,
    output logic            pri_accept,
    output logic            up_forward,
    output spcr_pkg::spcr_rsp_t dn_rsp,
    output logic            perr_act,
    output logic            err_msg,
    output logic            intx_msg
);
    always_comb begin
        pri_accept = pri_req & (pri_is_io ? io_en : mem_en);
        up_forward = dn_req & bm_en;
        if (dn_req && !bm_en && dn_nonposted) begin
            dn_rsp = spcr_pkg::SPCR_RSP_UR;
        end else if (dn_req && bm_en) begin
            dn_rsp = spcr_pkg::SPCR_RSP_OK;
        end else begin
            dn_rsp = spcr_pkg::SPCR_RSP_NONE;
        end
        perr_act = parity_err & perr_resp;
        err_msg = err_event & err_rep;
        intx_msg = (own_intx & ~int_dis) | fwd_intx;
    end
endmodule

//--- spcr_regs.sv
// Port identification and command register bank with transaction gating
//
// Function
// - Read-only vendor/device IDs, loadable defaults
// - I/O enable gates primary I/O
// - Memory enable gates primary memory
// - Master disable blocks upstream, marks non-posted UR
// - Rejected non-posted gets UR completion
// - Master enable forwards upstream reads/writes
// - Parity response bit selects parity action
// - Error-report bit gates fatal/non-fatal reporting
// - Interrupt disable blocks own INTx
// - Interrupt disable ignores forwarded INTx
// - Legacy command bits read zero
`timescale 1ns/100ps
module spcr_regs #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32,
    parameter int ID_W   = 16
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                cfg_wr,
    input  wire logic                cfg_rd,
    input  wire logic [ADDR_W-1:0]   cfg_addr,
    input  wire logic [DATA_W-1:0]   cfg_wdata,
    input  wire logic [DATA_W/8-1:0] cfg_be,
    input  wire logic                id_load,
    input  wire logic [ID_W-1:0]     id_load_maker,
    input  wire logic [ID_W-1:0]     id_load_part,
    input  wire logic                pri_req,
    input  wire logic                pri_is_io,
    input  wire logic                dn_req,
    input  wire logic                dn_nonposted,
    input  wire logic                parity_err,
    input  wire logic                err_event,
    input  wire logic                own_intx,
    input  wire logic                fwd_intx,
    output logic [DATA_W-1:0]        cfg_rdata,
    output logic                     cfg_rvalid,
    output logic                     pri_accept,
    output logic                     up_forward,
    output logic [1:0]               dn_rsp,
    output logic                     perr_act,
    output logic                     err_msg,
    output logic                     intx_msg,
    output logic [15:0]              command
);
    // Command register is two byte lanes wide
    localparam int CMD_W     = 16;
    localparam int CMD_LANES = CMD_W / 8;

    logic [ID_W-1:0]     maker_r;
    logic [ID_W-1:0]     part_r;
    logic [CMD_W-1:0]    cmd_r;
    logic [CMD_W-1:0]    cmd_nxt;
    wire  [CMD_W-1:0]    lane_w;
    logic                cmd_hit;
    logic                acc_c;
    logic                up_c;
    spcr_pkg::spcr_rsp_t rsp_c;
    logic                perr_c;
    logic                err_c;
    logic                intx_c;

    // Offset match shared by the write and read paths
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0]        off);
        return addr == ADDR_W'(off);
    endfunction

    // Identity word, maker in the low half
    function automatic logic [DATA_W-1:0] id_word(input logic [ID_W-1:0] maker,
                                                  input logic [ID_W-1:0] part);
        logic [DATA_W-1:0] word;
        word = {DATA_W{1'b0}};
        word[spcr_pkg::VEND_LSB +: ID_W] = maker;
        word[spcr_pkg::PART_LSB +: ID_W] = part;
        return word;
    endfunction

    // IDs change only by reset or side-band load
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            maker_r <= spcr_pkg::MAKER_ID_RST;
            part_r  <= spcr_pkg::PART_ID_RST;
        end else if (id_load) begin
            maker_r <= id_load_maker;
            part_r  <= id_load_part;
        end
    end

    assign cmd_hit = cfg_wr && addr_hit(cfg_addr, spcr_pkg::OFF_COMMAND);

    for (genvar g = 0; g < CMD_LANES; g++) begin : g_lane
        assign lane_w[8*g +: 8] = (cmd_hit && cfg_be[g]) ? cfg_wdata[8*g +: 8]
                                                        : cmd_r[8*g +: 8];
    end

    // legacy and reserved bits forced zero
    always_comb begin
        cmd_nxt = lane_w & spcr_pkg::CMD_WR_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmd_r <= spcr_pkg::CMD_RST;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // Read answers one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
        end
    end

    // Unmapped offsets and idle cycles read zero; reads see the old command
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_rdata <= {DATA_W{1'b0}};
        end else if (cfg_rd && addr_hit(cfg_addr, spcr_pkg::OFF_IDENT)) begin
            cfg_rdata <= id_word(maker_r, part_r);
        end else if (cfg_rd && addr_hit(cfg_addr, spcr_pkg::OFF_COMMAND)) begin
            cfg_rdata <= {{(DATA_W-CMD_W){1'b0}}, cmd_r};
        end else begin
            cfg_rdata <= {DATA_W{1'b0}};
        end
    end

    spcr_gate u_gate (
        .io_en        (cmd_r[spcr_pkg::CMD_IO_EN]),
        .mem_en       (cmd_r[spcr_pkg::CMD_MEM_EN]),
        .bm_en        (cmd_r[spcr_pkg::CMD_BM_EN]),
        .perr_resp    (cmd_r[spcr_pkg::CMD_PERR_RESP]),
        .err_rep      (cmd_r[spcr_pkg::CMD_ERR_REP]),
        .int_dis      (cmd_r[spcr_pkg::CMD_INT_DIS]),
        .pri_req      (pri_req),
        .pri_is_io    (pri_is_io),
        .dn_req       (dn_req),
        .dn_nonposted (dn_nonposted),
        .parity_err   (parity_err),
        .err_event    (err_event),
        .own_intx     (own_intx),
        .fwd_intx     (fwd_intx),
        .pri_accept   (acc_c),
        .up_forward   (up_c),
        .dn_rsp       (rsp_c),
        .perr_act     (perr_c),
        .err_msg      (err_c),
        .intx_msg     (intx_c)
    );

    // transaction decisions registered
    // One cycle of latency buys flop-driven outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pri_accept <= 1'b0;
            up_forward <= 1'b0;
            dn_rsp     <= spcr_pkg::SPCR_RSP_NONE;
        end else begin
            pri_accept <= acc_c;
            up_forward <= up_c;
            dn_rsp     <= rsp_c;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            perr_act <= 1'b0;
            err_msg  <= 1'b0;
        end else begin
            perr_act <= perr_c;
            err_msg  <= err_c;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            intx_msg <= 1'b0;
        end else begin
            intx_msg <= intx_c;
        end
    end

    // Mirror follows the register on the same edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            command <= spcr_pkg::CMD_RST;
        end else begin
            command <= cmd_nxt;
        end
    end
endmodule

//--- spcr_regs_props.sv
// Checker: command gating and fixed bits
`timescale 1ns/100ps
module spcr_props (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        pri_req,
    input wire logic        pri_is_io,
    input wire logic        dn_req,
    input wire logic        dn_nonposted,
    input wire logic        parity_err,
    input wire logic        err_event,
    input wire logic        own_intx,
    input wire logic        fwd_intx,
    input wire logic        pri_accept,
    input wire logic        up_forward,
    input wire logic [1:0]  dn_rsp,
    input wire logic        perr_act,
    input wire logic        err_msg,
    input wire logic        intx_msg,
    input wire logic [15:0] command
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_acc; pri_accept == $past(pri_req & command[!pri_is_io]); endproperty
    a_acc: assert property (p_acc) else $error("accept");
    property p_fwd; up_forward == $past(dn_req & command[2]); endproperty
    a_fwd: assert property (p_fwd) else $error("forward");
    property p_ur; dn_rsp == $past(!dn_req ? 2'h0 : command[2] ? 2'h1 : {dn_nonposted, 1'h0}); endproperty
    a_ur: assert property (p_ur) else $error("response");
    property p_par; perr_act == $past(parity_err & command[6]); endproperty
    a_par: assert property (p_par) else $error("parity");
    property p_err; err_msg == $past(err_event & command[8]); endproperty
    a_err: assert property (p_err) else $error("error");
    property p_int; intx_msg == $past(own_intx & !command[10] | fwd_intx); endproperty
    a_int: assert property (p_int) else $error("intx");
    property p_fix; (command & 16'hfab8) == 16'h0000; endproperty
    a_fix: assert property (p_fix) else $error("fixed bits");
    property p_rst; $past(reset) |-> command == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
endmodule
bind spcr_regs spcr_props i_spcr_props (.*);

//--- spcr_host.sv
// Root complex model: one config access per call
`timescale 1ns/100ps
module spcr_host (
    input  wire logic   ref_clk,
    output logic        cfg_wr = 1'h0,
    output logic        cfg_rd = 1'h0,
    output logic [7:0]  cfg_addr = 8'h00,
    output logic [31:0] cfg_wdata = 32'h0,
    output logic [3:0]  cfg_be = 4'h0
);
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(negedge ref_clk);
        cfg_wr = w;
        cfg_rd = !w;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_be = b;
        @(negedge ref_clk);
        cfg_wr = 1'h0;
        cfg_rd = 1'h0;
        // Released data inverted so stale copies are caught
        cfg_wdata = ~d;
    endtask
endmodule

//--- tb.sv
// Testbench: config reads checked through an expectation queue
`timescale 1ns/100ps
module tb;
    logic        ref_clk = 1'h0;
    logic        reset = 1'h1;
    logic        id_load = 1'h0;
    logic [31:0] ld = 32'h0;
    logic [15:0] cmd = 16'h0;
    logic [7:0]  ev = 8'h00;
    logic        cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [3:0]  cfg_be;
    logic [31:0] exp_q[$];
    logic [6:0]  gq[$];
    logic [15:0] mq[$];
    logic [15:0] cmd_m = 16'h0;
    wire  [15:0] cmd_o;
    wire  [6:0]  g_o;
    int          fails = 0;
    int          compares = 0;
    always #2 ref_clk = ~ref_clk;
    // Random events reach all gating inputs
    always @(negedge ref_clk) ev <= reset ? 8'h00 : 8'($urandom);
    spcr_host i_spcr_host (.*);
    spcr_regs i_spcr_regs (.ref_clk, .reset, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be,
        .id_load, .id_load_maker(ld[15:0]), .id_load_part(ld[31:16]), .pri_req(ev[0]),
        .pri_is_io(ev[1]), .dn_req(ev[2]), .dn_nonposted(ev[3]), .parity_err(ev[4]),
        .err_event(ev[5]), .own_intx(ev[6]), .fwd_intx(ev[7]), .cfg_rdata, .cfg_rvalid,
        .pri_accept(g_o[0]), .up_forward(g_o[1]), .dn_rsp(g_o[3:2]), .perr_act(g_o[4]),
        .err_msg(g_o[5]), .intx_msg(g_o[6]), .command(cmd_o));
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_g(input logic [6:0] e, input logic [6:0] g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("ERROR t=%0t gate exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_m(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("ERROR t=%0t command exp=%h got=%h", $time, e, g);
        end
    endtask
    // Gating expectation from the bench's own command model
    function automatic logic [6:0] g_exp(input logic [7:0] e, input logic [15:0] c);
        logic [1:0] r;
        r = !e[2] ? spcr_pkg::SPCR_RSP_NONE : c[spcr_pkg::CMD_BM_EN] ? spcr_pkg::SPCR_RSP_OK
            : e[3] ? spcr_pkg::SPCR_RSP_UR : spcr_pkg::SPCR_RSP_NONE;
        return {e[6] & ~c[spcr_pkg::CMD_INT_DIS] | e[7], e[5] & c[spcr_pkg::CMD_ERR_REP],
                e[4] & c[spcr_pkg::CMD_PERR_RESP], r, e[2] & c[spcr_pkg::CMD_BM_EN],
                e[0] & (e[1] ? c[spcr_pkg::CMD_IO_EN] : c[spcr_pkg::CMD_MEM_EN])};
    endfunction
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_spcr_host.acc(1'h0, a, 32'h0, 4'h0);
    endtask
    task automatic wrap_up;
        // Reads that never answered count as mismatches
        fails += exp_q.size();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (cfg_rvalid === 1'h1) begin
            if (exp_q.size() > 0) begin
                chk(exp_q.pop_front(), cfg_rdata);
            end else begin
                fails++;
            end
        end
    end
    // Model takes a command write on the same edge as the design
    always @(posedge ref_clk) begin
        if (reset) begin
            cmd_m <= 16'h0;
        end else begin
            gq.push_back(g_exp(ev, cmd_m));
            mq.push_back((cfg_wr && cfg_addr == spcr_pkg::OFF_COMMAND) ? cmd : cmd_m);
            if (cfg_wr && cfg_addr == spcr_pkg::OFF_COMMAND) cmd_m <= cmd;
        end
    end
    always @(negedge ref_clk) begin
        if (gq.size() > 0) begin
            chk_g(gq.pop_front(), g_o);
        end
        if (mq.size() > 0) begin
            chk_m(mq.pop_front(), cmd_o);
        end
    end
    initial begin
        logic [31:0] d;
        d = $urandom(32'hc49a8f96);
        repeat (4) @(negedge ref_clk);
        reset = 1'h0;
        rd(8'h04, 32'h0);
        rd(8'h00, {spcr_pkg::PART_ID_RST, spcr_pkg::MAKER_ID_RST});
        i_spcr_host.acc(1'h1, 8'h00, $urandom, 4'hf);
        rd(8'h00, {spcr_pkg::PART_ID_RST, spcr_pkg::MAKER_ID_RST});
        ld = $urandom;
        id_load = 1'h1;
        @(negedge ref_clk);
        id_load = 1'h0;
        rd(8'h00, ld);
        repeat (40) begin
            d = $urandom;
            if (d[16]) cmd[7:0] = d[7:0] & spcr_pkg::CMD_WR_MASK[7:0];
            if (d[17]) cmd[15:8] = d[15:8] & spcr_pkg::CMD_WR_MASK[15:8];
            i_spcr_host.acc(1'h1, 8'h04, d, d[19:16]);
            rd(8'h04, {16'h0, cmd});
        end
        // Second reset must clear written bits and restore default ids
        reset = 1'h1;
        cmd = 16'h0;
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        rd(8'h04, 32'h0);
        rd(8'h00, {spcr_pkg::PART_ID_RST, spcr_pkg::MAKER_ID_RST});
        rd(8'h08, 32'h0);
        repeat (4) @(negedge ref_clk);
        wrap_up;
    end
    initial begin
        #20000;
        fails++;
        wrap_up;
    end
endmodule
